// >>> design/lac_cmd_interp.sv
// ascii command interpreter: ramp times, program run, calibration, status
// assumes rx and tx character handshakes come from logic on sys_clk
`timescale 1ns/10ps
module lac_cmd_interp #(
   parameter int RAMP_W = 16
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   output logic rxReady,
   output logic txValid,
   output logic [7:0] txData,
   input wire logic txReady,
   input wire lac_pkg::lac_status_pins_t statusPins,
   output logic [RAMP_W-1:0] rampUpMs,
   output logic [RAMP_W-1:0] rampDownMs,
   output logic programRun,
   output logic [7:0] programNumber,
   output logic calibrationOn,
   output logic [31:0] deviceStatusWord
);
   typedef enum logic [2:0] {
      ST_COLLECT = 3'b000,
      ST_NAME = 3'b001,
      ST_WAIT_NUM = 3'b010,
      ST_DIGITS = 3'b011,
      ST_ERROR = 3'b100,
      ST_CR = 3'b101
   } lac_phase_t;

   typedef struct packed {
      lac_phase_t phase;
      logic [31:0] nameBuf;
      logic [2:0] nameLen;
      logic [31:0] numVal;
      logic numSeen;
      logic sepSeen;
      logic bad;
      logic rxReady;
      logic txValid;
      logic [7:0] txData;
      logic [3:0] idx;
      logic sendNum;
      logic [31:0] numOut;
      logic convStart;
      logic [RAMP_W-1:0] rampUp;
      logic [RAMP_W-1:0] rampDown;
      logic progRun;
      logic [7:0] progNum;
      logic calib;
      logic [31:0] statusSnap;
   } lac_state_t;

   lac_state_t s;
   lac_state_t next_s;
   lac_pkg::lac_status_pins_t pinsSync;
   logic [39:0] bcd;
   logic convDone;
   logic [31:0] statusNow;
   logic [7:0] rxChar;
   logic step;
   lac_pkg::lac_cmd_t cmd;
   logic argOk;

   function automatic logic [7:0] to_upper(input logic [7:0] c);
      to_upper = (c >= 8'h61 && c <= 8'h7A) ? 8'(c - 8'h20) : c;
   endfunction

   function automatic logic is_letter(input logic [7:0] c);
      is_letter = c >= 8'h41 && c <= 8'h5A;
   endfunction

   function automatic logic is_digit(input logic [7:0] c);
      is_digit = c >= 8'h30 && c <= 8'h39;
   endfunction

   function automatic logic [3:0] top_digit(input logic [39:0] b);
      top_digit = 4'h0;
      for (int i = 1; i < 10; i++) begin
         if (b[4*i +: 4] != 4'h0) begin
            top_digit = 4'(i);
         end
      end
   endfunction

   function automatic logic [7:0] digit_char(input logic [39:0] b, input logic [3:0] i);
      digit_char = 8'(lac_pkg::CHAR_ZERO + {4'h0, b[4*i +: 4]});
   endfunction

   lac_sync #(
      .W($bits(lac_pkg::lac_status_pins_t))
   ) u_sync (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .asyncIn(statusPins),
      .syncOut(pinsSync)
   );

   lac_bin2dec #(
      .W(32),
      .D(10)
   ) u_dec (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .start(s.convStart),
      .value(s.numOut),
      .bcd(bcd),
      .done(convDone)
   );

   // status word, bit n weighs two to the n
   always_comb begin
      statusNow = pinsSync.otherBits;
      statusNow[lac_pkg::BIT_EMISSION] = pinsSync.emissionOn;
      statusNow[lac_pkg::BIT_EXT_ANALOG] = pinsSync.extAnalogOn;
      statusNow[lac_pkg::BIT_POWER_CORR] = s.calib;
      statusNow[lac_pkg::BIT_READY] = pinsSync.laserReady;
      statusNow[lac_pkg::BIT_LEAK_1] = pinsSync.leak1;
      statusNow[lac_pkg::BIT_LEAK_2] = pinsSync.leak2;
      statusNow[lac_pkg::BIT_SLOW_RAMP] = pinsSync.slowRampOn;
      statusNow[lac_pkg::BIT_REMOTE] = pinsSync.remoteMode;
      statusNow[lac_pkg::BIT_FLOW_1] = pinsSync.flowAlarm1;
      statusNow[lac_pkg::BIT_FLOW_2] = pinsSync.flowAlarm2;
      statusNow[lac_pkg::BIT_RED_EXT] = pinsSync.redExternal;
      statusNow[lac_pkg::BIT_INTERLOCK] = pinsSync.interlockBad;
   end

   assign rxChar = to_upper(rxData);
   assign step = !s.txValid || txReady;
   assign cmd = s.bad ? lac_pkg::CMD_NONE : lac_pkg::lac_decode(s.nameBuf);
   assign argOk = (cmd == lac_pkg::CMD_SET_UP || cmd == lac_pkg::CMD_SET_DOWN ||
                   cmd == lac_pkg::CMD_PROG_BEGIN) ? s.numSeen : !s.numSeen;

   always_comb begin
      next_s = s;
      next_s.convStart = 1'b0;
      case (s.phase)
         ST_COLLECT: begin
            if (rxValid) begin
               if (rxChar == lac_pkg::CHAR_CR) begin
                  next_s.rxReady = 1'b0;
                  next_s.txValid = 1'b1;
                  next_s.nameBuf = '0;
                  next_s.nameLen = 3'h0;
                  next_s.numVal = '0;
                  next_s.numSeen = 1'b0;
                  next_s.sepSeen = 1'b0;
                  next_s.bad = 1'b0;
                  next_s.sendNum = 1'b0;
                  if (cmd == lac_pkg::CMD_NONE || !argOk) begin
                     next_s.phase = ST_ERROR;
                     next_s.txData = lac_pkg::ERR_TEXT[95 -: 8];
                     next_s.idx = 4'h1;
                  end else begin
                     next_s.phase = ST_NAME;
                     next_s.txData = s.nameBuf[8*({1'b0, s.nameLen} - 4'h1) +: 8];
                     next_s.idx = 4'({1'b0, s.nameLen} - 4'h1);
                     next_s.nameBuf = s.nameBuf;
                     next_s.nameLen = s.nameLen;
                     case (cmd)
                        lac_pkg::CMD_SET_UP: begin
                           next_s.rampUp = s.numVal[RAMP_W-1:0];
                           next_s.numOut = 32'(s.numVal[RAMP_W-1:0]);
                           next_s.sendNum = 1'b1;
                        end
                        lac_pkg::CMD_SET_DOWN: begin
                           next_s.rampDown = s.numVal[RAMP_W-1:0];
                           next_s.numOut = 32'(s.numVal[RAMP_W-1:0]);
                           next_s.sendNum = 1'b1;
                        end
                        lac_pkg::CMD_READ_UP: begin
                           next_s.numOut = 32'(s.rampUp);
                           next_s.sendNum = 1'b1;
                        end
                        lac_pkg::CMD_READ_DOWN: begin
                           next_s.numOut = 32'(s.rampDown);
                           next_s.sendNum = 1'b1;
                        end
                        lac_pkg::CMD_PROG_BEGIN: begin
                           next_s.progRun = 1'b1;
                           next_s.progNum = s.numVal[7:0];
                           next_s.numOut = 32'(s.numVal[7:0]);
                           next_s.sendNum = 1'b1;
                        end
                        lac_pkg::CMD_PROG_HALT: next_s.progRun = 1'b0;
                        lac_pkg::CMD_CAL_ON: next_s.calib = 1'b1;
                        lac_pkg::CMD_CAL_OFF: next_s.calib = 1'b0;
                        lac_pkg::CMD_STATUS: begin
                           next_s.statusSnap = statusNow;
                           next_s.numOut = statusNow;
                           next_s.sendNum = 1'b1;
                        end
                        default: next_s.sendNum = 1'b0;
                     endcase
                     next_s.convStart = next_s.sendNum;
                  end
               end else if (rxChar == lac_pkg::CHAR_LF) begin
                  next_s.bad = s.bad;
               end else if (is_letter(rxChar)) begin
                  if (s.sepSeen || s.numSeen || s.nameLen == lac_pkg::NAME_MAX) begin
                     next_s.bad = 1'b1;
                  end else begin
                     next_s.nameBuf = {s.nameBuf[23:0], rxChar};
                     next_s.nameLen = 3'(s.nameLen + 3'h1);
                  end
               end else if (rxChar == lac_pkg::CHAR_SPACE) begin
                  next_s.sepSeen = s.nameLen != 3'h0;
               end else if (is_digit(rxChar)) begin
                  next_s.numSeen = 1'b1;
                  next_s.sepSeen = 1'b1;
                  next_s.numVal = 32'(s.numVal * 32'h0000_000A + {28'h000_0000, rxChar[3:0]});
               end else begin
                  next_s.bad = 1'b1;
               end
            end
         end
         ST_NAME: begin
            if (step) begin
               if (s.idx != 4'h0) begin
                  next_s.idx = 4'(s.idx - 4'h1);
                  next_s.txData = s.nameBuf[8*(s.idx - 4'h1) +: 8];
               end else if (s.sendNum) begin
                  next_s.txData = lac_pkg::CHAR_COLON;
                  next_s.phase = ST_WAIT_NUM;
               end else begin
                  next_s.txData = lac_pkg::CHAR_CR;
                  next_s.phase = ST_CR;
               end
            end
         end
         ST_WAIT_NUM: begin
            if (step) begin
               if (convDone) begin
                  next_s.txValid = 1'b1;
                  next_s.idx = top_digit(bcd);
                  next_s.txData = digit_char(bcd, top_digit(bcd));
                  next_s.phase = ST_DIGITS;
               end else begin
                  next_s.txValid = 1'b0;
               end
            end
         end
         ST_DIGITS: begin
            if (step) begin
               if (s.idx == 4'h0) begin
                  next_s.txData = lac_pkg::CHAR_CR;
                  next_s.phase = ST_CR;
               end else begin
                  next_s.idx = 4'(s.idx - 4'h1);
                  next_s.txData = digit_char(bcd, 4'(s.idx - 4'h1));
               end
            end
         end
         ST_ERROR: begin
            if (step) begin
               if (s.idx == lac_pkg::ERR_LEN) begin
                  next_s.txData = lac_pkg::CHAR_CR;
                  next_s.phase = ST_CR;
               end else begin
                  next_s.txData = lac_pkg::ERR_TEXT[95 - 8*s.idx -: 8];
                  next_s.idx = 4'(s.idx + 4'h1);
               end
            end
         end
         ST_CR: begin
            if (step) begin
               next_s.txValid = 1'b0;
               next_s.rxReady = 1'b1;
               next_s.nameBuf = '0;
               next_s.nameLen = 3'h0;
               next_s.phase = ST_COLLECT;
            end
         end
         default: next_s.phase = ST_COLLECT;
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         s <= '{phase: ST_COLLECT, nameBuf: '0, nameLen: 3'h0, numVal: '0,
                numSeen: 1'b0, sepSeen: 1'b0, bad: 1'b0, rxReady: 1'b1,
                txValid: 1'b0, txData: 8'h00, idx: 4'h0, sendNum: 1'b0,
                numOut: '0, convStart: 1'b0, rampUp: '0, rampDown: '0,
                progRun: 1'b0, progNum: lac_pkg::PROG_RESET, calib: 1'b0,
                statusSnap: lac_pkg::STATUS_RESET};
      end else begin
         s <= next_s;
      end
   end

   assign rxReady = s.rxReady;
   assign txValid = s.txValid;
   assign txData = s.txData;
   assign rampUpMs = s.rampUp;
   assign rampDownMs = s.rampDown;
   assign programRun = s.progRun;
   assign programNumber = s.progNum;
   assign calibrationOn = s.calib;
   assign deviceStatusWord = s.statusSnap;

   logic crTaken;
   assign crTaken = s.phase == ST_COLLECT && rxValid && rxChar == lac_pkg::CHAR_CR;

   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   a_ramp_up_store: assert property (crTaken && cmd == lac_pkg::CMD_SET_UP && s.numSeen
      |=> rampUpMs == $past(s.numVal[RAMP_W-1:0])) else $error("ramp up not stored");
   a_ramp_read_value: assert property (crTaken && cmd == lac_pkg::CMD_READ_DOWN && argOk
      |=> s.numOut == 32'($past(s.rampDown)) && s.convStart) else $error("bad read");
   a_prog_begin_run: assert property (crTaken && cmd == lac_pkg::CMD_PROG_BEGIN && s.numSeen
      |=> programRun && programNumber == $past(s.numVal[7:0])) else $error("no run");
   a_prog_halt_stop: assert property (crTaken && cmd == lac_pkg::CMD_PROG_HALT && argOk
      |=> !programRun) else $error("program not halted");
   a_cal_enable_on: assert property (crTaken && cmd == lac_pkg::CMD_CAL_ON && argOk
      |=> calibrationOn ##1 $stable(calibrationOn)) else $error("cal not on");
   a_cal_disable_off: assert property (crTaken && cmd == lac_pkg::CMD_CAL_OFF && argOk
      |=> !calibrationOn) else $error("cal not off");
   a_error_reply_start: assert property (crTaken && cmd == lac_pkg::CMD_NONE
      |=> txValid && txData == 8'h43 && !rxReady) else $error("no error text");
   a_status_snap_corr: assert property (crTaken && cmd == lac_pkg::CMD_STATUS && argOk
      |=> deviceStatusWord[5] == $past(s.calib)) else $error("bit 5 wrong");
   a_tx_hold_stall: assert property (txValid && !txReady
      |=> txValid && $stable(txData)) else $error("tx char dropped");
   a_reply_ends_cr: assert property (s.phase == ST_CR && txValid && txReady
      |-> txData == lac_pkg::CHAR_CR ##1 rxReady) else $error("reply not ended");
endmodule

// >>> design/lac_pkg.sv
// shared constants, command codes and carriers for the ascii command interpreter
// assumes a byte stream link already framed into characters outside this block
package lac_pkg;

   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_LF = 8'h0A;
   localparam logic [7:0] CHAR_SPACE = 8'h20;
   localparam logic [7:0] CHAR_COLON = 8'h3A;
   localparam logic [7:0] CHAR_ZERO = 8'h30;
   localparam logic [95:0] ERR_TEXT = 96'h436F_6D6D_616E_6420_4572_7221;
   localparam logic [3:0] ERR_LEN = 4'hC;
   localparam logic [2:0] NAME_MAX = 3'h4;

   localparam logic [31:0] NAME_SET_UP = 32'h0053_5554;
   localparam logic [31:0] NAME_SET_DOWN = 32'h0053_4454;
   localparam logic [31:0] NAME_READ_UP = 32'h0052_5554;
   localparam logic [31:0] NAME_READ_DOWN = 32'h0052_4454;
   localparam logic [31:0] NAME_PROG_BEGIN = 32'h5053_5254;
   localparam logic [31:0] NAME_PROG_HALT = 32'h5053_5450;
   localparam logic [31:0] NAME_CAL_ON = 32'h0045_434D;
   localparam logic [31:0] NAME_CAL_OFF = 32'h0044_434D;
   localparam logic [31:0] NAME_STATUS = 32'h0053_5441;

   localparam int BIT_EMISSION = 2;
   localparam int BIT_EXT_ANALOG = 4;
   localparam int BIT_POWER_CORR = 5;
   localparam int BIT_READY = 9;
   localparam int BIT_LEAK_1 = 13;
   localparam int BIT_LEAK_2 = 14;
   localparam int BIT_SLOW_RAMP = 20;
   localparam int BIT_REMOTE = 21;
   localparam int BIT_FLOW_1 = 26;
   localparam int BIT_RED_EXT = 27;
   localparam int BIT_FLOW_2 = 28;
   localparam int BIT_INTERLOCK = 30;

   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam logic [7:0] PROG_RESET = 8'h00;

   typedef enum logic [3:0] {
      CMD_NONE = 4'h0,
      CMD_SET_UP = 4'h1,
      CMD_SET_DOWN = 4'h2,
      CMD_READ_UP = 4'h3,
      CMD_READ_DOWN = 4'h4,
      CMD_PROG_BEGIN = 4'h5,
      CMD_PROG_HALT = 4'h6,
      CMD_CAL_ON = 4'h7,
      CMD_CAL_OFF = 4'h8,
      CMD_STATUS = 4'h9
   } lac_cmd_t;

   // laser condition inputs; otherBits carries the remaining status positions
   typedef struct packed {
      logic emissionOn;
      logic extAnalogOn;
      logic laserReady;
      logic leak1;
      logic leak2;
      logic slowRampOn;
      logic remoteMode;
      logic flowAlarm1;
      logic flowAlarm2;
      logic redExternal;
      logic interlockBad;
      logic [31:0] otherBits;
   } lac_status_pins_t;

   function automatic lac_cmd_t lac_decode(input logic [31:0] name);
      case (name)
         NAME_SET_UP: lac_decode = CMD_SET_UP;
         NAME_SET_DOWN: lac_decode = CMD_SET_DOWN;
         NAME_READ_UP: lac_decode = CMD_READ_UP;
         NAME_READ_DOWN: lac_decode = CMD_READ_DOWN;
         NAME_PROG_BEGIN: lac_decode = CMD_PROG_BEGIN;
         NAME_PROG_HALT: lac_decode = CMD_PROG_HALT;
         NAME_CAL_ON: lac_decode = CMD_CAL_ON;
         NAME_CAL_OFF: lac_decode = CMD_CAL_OFF;
         NAME_STATUS: lac_decode = CMD_STATUS;
         default: lac_decode = CMD_NONE;
      endcase
   endfunction

endpackage

// >>> design/lac_sync.sv
// two flip-flop synchroniser for a vector of slow levels
// assumes each bit changes far slower than sys_clk
`timescale 1ns/10ps
module lac_sync #(
   parameter int W = 8
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [W-1:0] asyncIn,
   output logic [W-1:0] syncOut
);
   logic [W-1:0] stage1;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         stage1 <= '0;
         syncOut <= '0;
      end else begin
         stage1 <= asyncIn;
         syncOut <= stage1;
      end
   end
endmodule

// >>> design/lac_bin2dec.sv
// sequential binary to packed bcd converter, one bit per clock
// assumes start is a one-cycle pulse; done stays high until the next start
`timescale 1ns/10ps
module lac_bin2dec #(
   parameter int W = 32,
   parameter int D = 10
) (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic start,
   input wire logic [W-1:0] value,
   output logic [4*D-1:0] bcd,
   output logic done
);
   logic [W-1:0] bin;
   logic [5:0] count;
   logic busy;
   logic [4*D-1:0] adj;

   always_comb begin
      adj = bcd;
      for (int i = 0; i < D; i++) begin
         if (bcd[4*i +: 4] > 4'h4) begin
            adj[4*i +: 4] = 4'(bcd[4*i +: 4] + 4'h3);
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         bin <= '0;
         bcd <= '0;
         count <= 6'h00;
         busy <= 1'b0;
         done <= 1'b0;
      end else if (start) begin
         bin <= value;
         bcd <= '0;
         count <= 6'(W);
         busy <= 1'b1;
         done <= 1'b0;
      end else if (busy) begin
         bcd <= {adj[4*D-2:0], bin[W-1]};
         bin <= {bin[W-2:0], 1'b0};
         count <= 6'(count - 6'h01);
         if (count == 6'h01) begin
            busy <= 1'b0;
            done <= 1'b1;
         end
      end
   end
endmodule

// >>> tb/lac_host_model.sv
// host side model: sends command lines and gathers the replies
// assumes the interpreter samples both character links on rising sys_clk
`timescale 1ns/10ps
module lac_host_model (
   input wire logic sys_clk,
   output logic rxValid,
   output logic [7:0] rxData,
   input wire logic rxReady,
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady
);
   initial begin
      rxValid = 1'b0;
      rxData = 8'h00;
      txReady = 1'b0;
   end

   // one line out, reply in; stall is the percent chance of a refused character
   task automatic xfer(input string cmd, input int stall, output logic [255:0] rep,
         output bit ok);
      int i;
      int n;
      logic take;
      logic [7:0] c;
      rep = '0;
      ok = 1'b0;
      for (i = 0; i <= cmd.len(); i++) begin
         c = (i == cmd.len()) ? lac_pkg::CHAR_CR : cmd[i];
         @(negedge sys_clk);
         rxValid = 1'b1;
         rxData = c;
         for (n = 0; n < 200 && rxReady !== 1'b1; n++) begin
            @(negedge sys_clk);
         end
         if (n == 200) begin
            rxValid = 1'b0;
            return;
         end
      end
      @(negedge sys_clk);
      rxValid = 1'b0;
      rxData = ~c;
      take = 1'b0;
      // take decided at the falling edge, so the rising edge between is race free
      for (n = 0; n < 2000; n++) begin
         @(negedge sys_clk);
         if (take) begin
            rep = {rep[247:0], c};
            if (c === lac_pkg::CHAR_CR) begin
               ok = 1'b1;
               txReady = 1'b0;
               break;
            end
         end
         txReady = ($urandom_range(99) >= stall);
         c = txData;
         take = txValid & txReady;
      end
   endtask
endmodule

// >>> tb/tb.sv
// self-checking bench for the ascii command interpreter
// assumes lac_host_model plays the host on the character links
`timescale 1ns/10ps
module tb;
   logic sys_clk;
   logic reset_n;
   logic rxValid;
   logic [7:0] rxData;
   logic rxReady;
   logic txValid;
   logic [7:0] txData;
   logic txReady;
   lac_pkg::lac_status_pins_t statusPins;
   logic [15:0] rampUpMs;
   logic [15:0] rampDownMs;
   logic programRun;
   logic [7:0] programNumber;
   logic calibrationOn;
   logic [31:0] deviceStatusWord;
   int err_total;
   int total_checks;

   lac_cmd_interp #(.RAMP_W(16)) dut (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .rxValid(rxValid),
      .rxData(rxData),
      .rxReady(rxReady),
      .txValid(txValid),
      .txData(txData),
      .txReady(txReady),
      .statusPins(statusPins),
      .rampUpMs(rampUpMs),
      .rampDownMs(rampDownMs),
      .programRun(programRun),
      .programNumber(programNumber),
      .calibrationOn(calibrationOn),
      .deviceStatusWord(deviceStatusWord)
   );

   lac_host_model host (
      .sys_clk(sys_clk),
      .rxValid(rxValid),
      .rxData(rxData),
      .rxReady(rxReady),
      .txValid(txValid),
      .txData(txData),
      .txReady(txReady)
   );

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [255:0] seen, input logic [255:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // reply text packed one character per byte, closing cr appended
   function automatic logic [255:0] pack(input string s);
      pack = '0;
      for (int i = 0; i < s.len(); i++) begin
         pack = {pack[247:0], s[i]};
      end
      pack = {pack[247:0], 8'h0D};
   endfunction

   // command name text from its packed code; a set bit of lc lowers that byte
   function automatic string nm(input logic [31:0] n, input logic [3:0] lc);
      nm = "";
      for (int i = 3; i >= 0; i--) begin
         if (n[8*i +: 8] != 8'h00) begin
            nm = $sformatf("%s%c", nm, n[8*i +: 8] | {2'b00, lc[i], 5'h00});
         end
      end
   endfunction

   task automatic run(input string cmd, input string exp);
      logic [255:0] rep;
      bit ok;
      host.xfer(cmd, $urandom_range(60), rep, ok);
      if (!ok) begin
         err_total++;
         end_of_test();
      end else begin
         check(rep, pack(exp));
      end
   endtask

   function automatic logic [31:0] exp_word(input lac_pkg::lac_status_pins_t p,
         input logic cal);
      logic [31:0] w;
      w = p.otherBits;
      w[2] = p.emissionOn;
      w[4] = p.extAnalogOn;
      w[5] = cal;
      w[9] = p.laserReady;
      w[13] = p.leak1;
      w[14] = p.leak2;
      w[20] = p.slowRampOn;
      w[21] = p.remoteMode;
      w[26] = p.flowAlarm1;
      w[27] = p.redExternal;
      w[28] = p.flowAlarm2;
      w[30] = p.interlockBad;
      return w;
   endfunction

   initial begin
      int v;
      logic [31:0] ev;
      logic cal;
      logic [31:0] na;
      logic [31:0] nb;
      string errs[8];
      reset_n = 1'b0;
      statusPins = '0;
      err_total = 0;
      total_checks = 0;
      v = $urandom(83);
      repeat (16) @(negedge sys_clk);
      check({rxReady, txValid, txData, rampUpMs, rampDownMs, programRun, programNumber,
         calibrationOn, deviceStatusWord}, {1'b1, 83'h0});
      reset_n = 1'b1;
      $display("test reset done");
      // ramps: zero, full scale, random, mixed letter case
      for (int i = 0; i < 6; i++) begin
         v = (i == 0) ? 0 : (i == 1) ? 65535 : $urandom_range(65535);
         na = i[0] ? lac_pkg::NAME_SET_DOWN : lac_pkg::NAME_SET_UP;
         nb = i[0] ? lac_pkg::NAME_READ_DOWN : lac_pkg::NAME_READ_UP;
         run($sformatf("%s %0d", nm(na, 4'(i)), v),
            $sformatf("%s:%0d", nm(na, 4'h0), v));
         check(i[0] ? rampDownMs : rampUpMs, v);
         run(i[0] ? nm(nb, 4'(i + 2)) : $sformatf("%s ", nm(nb, 4'(i + 2))),
            $sformatf("%s:%0d", nm(nb, 4'h0), v));
      end
      run($sformatf("%s 65537", nm(lac_pkg::NAME_SET_UP, 4'h0)),
         $sformatf("%s:1", nm(lac_pkg::NAME_SET_UP, 4'h0)));
      check(rampUpMs, 16'h0001);
      $display("test ramps done");
      na = lac_pkg::NAME_PROG_BEGIN;
      nb = lac_pkg::NAME_PROG_HALT;
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 300 : $urandom_range(255);
         run($sformatf("%s %0d", nm(na, 4'hF), v),
            $sformatf("%s:%0d", nm(na, 4'h0), v % 256));
         check({programRun, programNumber}, {1'b1, 8'(v)});
         run(i[0] ? $sformatf("%s\n", nm(nb, 4'(i))) : nm(nb, 4'(i)), nm(nb, 4'h0));
         check({programRun, programNumber}, {1'b0, 8'(v)});
      end
      $display("test program done");
      na = lac_pkg::NAME_SET_UP;
      errs = '{"BGM", nm(na, 4'h0), $sformatf("%s 5", nm(lac_pkg::NAME_CAL_ON, 4'h7)),
         nm(lac_pkg::NAME_PROG_BEGIN, 4'h0), $sformatf("%sX 1", nm(na, 4'h0)),
         $sformatf("%s 1", nm(lac_pkg::NAME_STATUS, 4'h0)),
         $sformatf("%s 5.5", nm(na, 4'h0)), "ABCDE"};
      foreach (errs[i]) begin
         run(errs[i], "Command Err!");
      end
      $display("test errors done");
      for (int i = 0; i < 8; i++) begin
         cal = i[0];
         na = cal ? lac_pkg::NAME_CAL_ON : lac_pkg::NAME_CAL_OFF;
         run(nm(na, 4'(i)), nm(na, 4'h0));
         check(calibrationOn, cal);
         statusPins = (i == 0) ? '1 : (i == 1) ? '0 : 43'({$urandom, $urandom});
         repeat (4) @(negedge sys_clk);
         ev = exp_word(statusPins, cal);
         run(nm(lac_pkg::NAME_STATUS, 4'(7 - i)),
            $sformatf("%s:%0d", nm(lac_pkg::NAME_STATUS, 4'h0), ev));
         check(deviceStatusWord, ev);
      end
      $display("test status done");
      end_of_test();
   end
endmodule
